// ### logic/exec_pkg.sv
package exec_pkg;

    localparam int DATA_W    = 8;
    localparam int PC_W      = 13;
    localparam int ADDR_W    = 8;
    localparam int OPC_W     = 6;
    localparam int BIT_SEL_W = 3;

    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_INSTR  = 4'h4;
    localparam logic [3:0] REG_STATE  = 4'h8;
    localparam logic [3:0] REG_PC     = 4'hc;

    localparam int INSTR_OP_LSB   = 0;
    localparam int INSTR_BIT_LSB  = 8;
    localparam int INSTR_IMM_LSB  = 16;
    localparam int INSTR_ADDR_LSB = 24;

    localparam int ST_WREG_LSB = 0;
    localparam int ST_TABLE_HIGH_BYTE_LSB = 8;
    localparam int ST_C        = 16;
    localparam int ST_AC       = 17;
    localparam int ST_Z        = 18;
    localparam int ST_OV       = 19;
    localparam int ST_TO       = 20;
    localparam int ST_PDF      = 21;
    localparam int ST_IRQ_EN   = 22;
    localparam int ST_HALTED   = 23;
    localparam int ST_BUSY     = 24;

    localparam int CTRL_GO     = 0;
    localparam int CTRL_WAKE   = 1;

    localparam logic [PC_W-1:0] LAST_PAGE_BASE = 13'h1f00;
    localparam logic [ADDR_W-1:0] PCL_ADDR     = 8'h06;
    localparam logic [DATA_W-1:0] ALL_ONES     = 8'hff;
    localparam logic [DATA_W-1:0] ALL_ZEROS    = 8'h00;

    typedef enum logic [OPC_W-1:0] {
        idle_op, copy_mem_to_wreg_op, copy_imm_to_wreg_op, copy_wreg_to_mem_op,
        zero_bit_op, set_bit_op, goto_op, skip_zero_op, skip_zero_copy_op,
        skip_bit_zero_op, skip_bit_nonzero_op, inc_skip_zero_op, dec_skip_zero_op,
        inc_skip_zero_to_wreg_op, dec_skip_zero_to_wreg_op, call_op,
        subroutine_exit_op, subroutine_exit_imm_op, interrupt_exit_op,
        table_fetch_op, table_fetch_last_page_op, zero_op, set_byte_op,
        watchdog_kick_op, watchdog_kick_first_half_op, watchdog_kick_second_half_op,
        nibble_exchange_op, nibble_exchange_to_wreg_op, halt_op,
        add_mem_op, sum_to_mem_op, add_imm_op, add_with_carry_op,
        add_with_carry_to_mem_op, and_mem_op, bitwise_conj_to_mem_op,
        and_imm_op, invert_op
    } opcode_e;

    typedef struct packed {
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    imm;
        logic [4:0]           pad;
        logic [BIT_SEL_W-1:0] bit_sel;
        logic [1:0]           pad2;
        logic [OPC_W-1:0]     op;
    } instr_s;

    typedef struct packed {
        logic c;
        logic ac;
        logic z;
        logic ov;
    } alu_flags_s;

endpackage

// ### logic/mcu_instruction_execute.sv
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module mcu_instruction_execute
    import exec_pkg::*;
#(
    parameter int STACK_DEPTH = 8,
    parameter int WDT_W       = 16,
    parameter int PRESC_W     = 8
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic [ADDR_W-1:0] o_dmem_addr,
    output logic             o_dmem_we,
    output logic [DATA_W-1:0] o_dmem_wdata,
    input  wire logic [DATA_W-1:0] i_dmem_rdata,
    output logic [PC_W-1:0]  o_pmem_addr,
    input  wire logic [15:0] i_pmem_rdata,
    output logic             o_sys_clk_stop,
    output logic             o_watchdog_timeout
);

    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_EXEC, ST_SECOND, ST_DONE} phase_e;

    phase_e                 phase_q;
    instr_s                 instr_q;
    logic [DATA_W-1:0]      working_register_q;
    logic [DATA_W-1:0]      table_high_byte_q;
    alu_flags_s             flags_q;
    logic                   watchdog_timeout_flag_q;
    logic                   powerdown_flag_q;
    logic                   global_irq_enable_q;
    logic                   halted_q;
    logic                   half_kick_pend_q;
    logic                   half_kick_first_q;
    logic [WDT_W-1:0]       watchdog_counter_q;
    logic [PRESC_W-1:0]     prescaler_q;
    logic [PC_W-1:0]        pc_q;
    logic [PC_W-1:0]        stack_q [STACK_DEPTH];
    logic [$clog2(STACK_DEPTH)-1:0] sp_q;
    logic [DATA_W-1:0]      mem_q;
    logic [15:0]            tbl_q;
    logic [1:0]             cycles_q;
    logic                   rd_ack_q;
    logic                   go;
    logic                   wake;
    logic [DATA_W-1:0]      res;
    logic                   res_to_mem;
    logic                   res_to_wreg;
    logic                   skip;
    logic                   two_cyc;
    logic                   upd_z;
    logic                   upd_arith;
    alu_flags_s             arith;
    logic [DATA_W:0]        sum;
    logic [4:0]             nib_sum;
    logic [DATA_W-1:0]      add_b;
    logic                   cin;
    logic [DATA_W-1:0]      bit_mask;

    assign go   = i_avs_write && i_avs_address == REG_CTRL && i_avs_byteenable[0]
                  && i_avs_writedata[CTRL_GO] && phase_q == ST_IDLE && !halted_q;
    assign wake = i_avs_write && i_avs_address == REG_CTRL && i_avs_byteenable[0]
                  && i_avs_writedata[CTRL_WAKE];
    assign bit_mask = DATA_W'(1) << instr_q.bit_sel;

    always_comb begin
        res         = mem_q;
        res_to_mem  = 1'b0;
        res_to_wreg = 1'b0;
        skip        = 1'b0;
        two_cyc     = 1'b0;
        upd_z       = 1'b0;
        upd_arith   = 1'b0;
        cin         = 1'b0;
        add_b       = mem_q;
        unique case (instr_q.op)
            add_imm_op, and_imm_op, copy_imm_to_wreg_op: add_b = instr_q.imm;
            add_with_carry_op, add_with_carry_to_mem_op: cin = flags_q.c;
            default: add_b = mem_q;
        endcase
        sum     = {1'b0, working_register_q} + {1'b0, add_b} + {{DATA_W{1'b0}}, cin};
        nib_sum = {1'b0, working_register_q[3:0]} + {1'b0, add_b[3:0]} + {4'h0, cin};
        arith.c  = sum[DATA_W];
        arith.ac = nib_sum[4];
        arith.z  = sum[DATA_W-1:0] == ALL_ZEROS;
        arith.ov = (working_register_q[7] == add_b[7]) && (sum[7] != add_b[7]);
        unique case (instr_q.op)
            copy_mem_to_wreg_op: begin res = mem_q; res_to_wreg = 1'b1; end
            copy_imm_to_wreg_op: begin res = instr_q.imm; res_to_wreg = 1'b1; end
            copy_wreg_to_mem_op: begin res = working_register_q; res_to_mem = 1'b1; end
            zero_bit_op: begin res = mem_q & ~bit_mask; res_to_mem = 1'b1; end
            set_bit_op:  begin res = mem_q | bit_mask; res_to_mem = 1'b1; end
            goto_op, call_op, subroutine_exit_op, interrupt_exit_op: two_cyc = 1'b1;
            subroutine_exit_imm_op: begin
                res = instr_q.imm; res_to_wreg = 1'b1; two_cyc = 1'b1;
            end
            skip_zero_op: skip = mem_q == ALL_ZEROS;
            skip_zero_copy_op: begin
                res_to_wreg = 1'b1; skip = mem_q == ALL_ZEROS;
            end
            skip_bit_zero_op:    skip = (mem_q & bit_mask) == ALL_ZEROS;
            skip_bit_nonzero_op: skip = (mem_q & bit_mask) != ALL_ZEROS;
            inc_skip_zero_op, inc_skip_zero_to_wreg_op: begin
                res = mem_q + 8'h01; skip = res == ALL_ZEROS;
                res_to_mem  = instr_q.op == inc_skip_zero_op;
                res_to_wreg = !res_to_mem;
            end
            dec_skip_zero_op, dec_skip_zero_to_wreg_op: begin
                res = mem_q - 8'h01; skip = res == ALL_ZEROS;
                res_to_mem  = instr_q.op == dec_skip_zero_op;
                res_to_wreg = !res_to_mem;
            end
            table_fetch_op, table_fetch_last_page_op: begin
                res = tbl_q[7:0]; res_to_mem = 1'b1; two_cyc = 1'b1;
            end
            zero_op:     begin res = ALL_ZEROS; res_to_mem = 1'b1; end
            set_byte_op: begin res = ALL_ONES; res_to_mem = 1'b1; end
            nibble_exchange_op: begin res = {mem_q[3:0], mem_q[7:4]}; res_to_mem = 1'b1; end
            nibble_exchange_to_wreg_op: begin
                res = {mem_q[3:0], mem_q[7:4]}; res_to_wreg = 1'b1;
            end
            add_mem_op, add_imm_op, add_with_carry_op: begin
                res = sum[DATA_W-1:0]; res_to_wreg = 1'b1; upd_arith = 1'b1;
            end
            sum_to_mem_op, add_with_carry_to_mem_op: begin
                res = sum[DATA_W-1:0]; res_to_mem = 1'b1; upd_arith = 1'b1;
            end
            and_mem_op, and_imm_op: begin
                res = working_register_q & add_b; res_to_wreg = 1'b1; upd_z = 1'b1;
            end
            bitwise_conj_to_mem_op: begin
                res = working_register_q & mem_q; res_to_mem = 1'b1; upd_z = 1'b1;
            end
            invert_op: begin res = ~mem_q; res_to_mem = 1'b1; upd_z = 1'b1; end
            default: res = mem_q;
        endcase
        if (res_to_mem && instr_q.addr == PCL_ADDR) two_cyc = 1'b1;
        if (skip) two_cyc = 1'b1;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_q  <= ST_IDLE;
            mem_q    <= '0;
            tbl_q    <= '0;
            cycles_q <= '0;
        end else begin
            unique case (phase_q)
                ST_IDLE: if (go) phase_q <= ST_READ;
                ST_READ: begin
                    mem_q   <= i_dmem_rdata;
                    tbl_q   <= i_pmem_rdata;
                    phase_q <= ST_EXEC;
                end
                ST_EXEC: begin
                    cycles_q <= two_cyc ? 2'd2 : 2'd1;
                    phase_q  <= two_cyc ? ST_SECOND : ST_DONE;
                end
                ST_SECOND: phase_q <= ST_DONE;
                ST_DONE:   phase_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            instr_q <= '0;
        end else if (i_avs_write && i_avs_address == REG_INSTR && phase_q == ST_IDLE) begin
            instr_q <= i_avs_writedata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            working_register_q <= '0;
            table_high_byte_q  <= '0;
            flags_q            <= '0;
        end else if (phase_q == ST_EXEC) begin
            if (res_to_wreg) working_register_q <= res;
            if (instr_q.op == table_fetch_op || instr_q.op == table_fetch_last_page_op)
                table_high_byte_q <= tbl_q[15:8];
            if (upd_arith) flags_q <= arith;
            if (upd_z) flags_q.z <= res == ALL_ZEROS;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pc_q <= '0;
            sp_q <= '0;
            global_irq_enable_q <= 1'b0;
            for (int k = 0; k < STACK_DEPTH; k++) stack_q[k] <= '0;
        end else if (phase_q == ST_EXEC) begin
            unique case (instr_q.op)
                goto_op: pc_q <= PC_W'(instr_q.addr);
                call_op: begin
                    stack_q[sp_q] <= pc_q + 13'd1;
                    sp_q <= sp_q + 1'b1;
                    pc_q <= PC_W'(instr_q.addr);
                end
                subroutine_exit_op, subroutine_exit_imm_op, interrupt_exit_op: begin
                    pc_q <= stack_q[sp_q - 1'b1];
                    sp_q <= sp_q - 1'b1;
                    if (instr_q.op == interrupt_exit_op) global_irq_enable_q <= 1'b1;
                end
                default: pc_q <= pc_q + (skip ? 13'd2 : 13'd1);
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            watchdog_counter_q      <= '0;
            prescaler_q             <= '0;
            watchdog_timeout_flag_q <= 1'b0;
            powerdown_flag_q        <= 1'b0;
            halted_q                <= 1'b0;
            half_kick_pend_q        <= 1'b0;
            half_kick_first_q       <= 1'b0;
        end else begin
            if (!halted_q) begin
                prescaler_q <= prescaler_q + 1'b1;
                if (&prescaler_q) watchdog_counter_q <= watchdog_counter_q + 1'b1;
            end
            if (!halted_q && &prescaler_q && &watchdog_counter_q) watchdog_timeout_flag_q <= 1'b1;
            if (wake) halted_q <= 1'b0;
            if (phase_q == ST_EXEC) begin
                unique case (instr_q.op)
                    watchdog_kick_op: begin
                        watchdog_counter_q      <= '0;
                        prescaler_q             <= '0;
                        watchdog_timeout_flag_q <= 1'b0;
                        powerdown_flag_q        <= 1'b0;
                    end
                    watchdog_kick_first_half_op, watchdog_kick_second_half_op: begin
                        if (half_kick_pend_q && half_kick_first_q !=
                            (instr_q.op == watchdog_kick_first_half_op)) begin
                            watchdog_counter_q      <= '0;
                            prescaler_q             <= '0;
                            watchdog_timeout_flag_q <= 1'b0;
                            powerdown_flag_q        <= 1'b0;
                            half_kick_pend_q        <= 1'b0;
                        end else begin
                            half_kick_pend_q  <= 1'b1;
                            half_kick_first_q <= instr_q.op == watchdog_kick_first_half_op;
                        end
                    end
                    halt_op: begin
                        watchdog_counter_q      <= '0;
                        prescaler_q             <= '0;
                        watchdog_timeout_flag_q <= 1'b0;
                        powerdown_flag_q        <= 1'b1;
                        halted_q                <= 1'b1;
                        half_kick_pend_q        <= 1'b0;
                    end
                    default: half_kick_pend_q <= 1'b0;
                endcase
            end
        end
    end

    always_comb begin
        o_dmem_addr  = instr_q.addr;
        o_dmem_we    = phase_q == ST_EXEC && res_to_mem;
        o_dmem_wdata = res;
        o_pmem_addr  = instr_q.op == table_fetch_last_page_op ?
                       (LAST_PAGE_BASE | PC_W'(working_register_q)) :
                       PC_W'({table_high_byte_q, working_register_q});
    end

    assign o_sys_clk_stop     = halted_q;
    assign o_watchdog_timeout = watchdog_timeout_flag_q;
    assign o_avs_waitrequest  = i_avs_read && !rd_ack_q;

    // read data registered on the first cycle, released on the second
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_avs_readdata <= '0;
            rd_ack_q       <= 1'b0;
        end else begin
            rd_ack_q <= i_avs_read && !rd_ack_q;
        end
        if (i_reset_n && i_avs_read && !rd_ack_q) begin
            unique case (i_avs_address)
                REG_INSTR: o_avs_readdata <= instr_q;
                REG_STATE: o_avs_readdata <= {7'h00, phase_q != ST_IDLE, halted_q,
                    global_irq_enable_q, powerdown_flag_q, watchdog_timeout_flag_q,
                    flags_q.ov, flags_q.z, flags_q.ac, flags_q.c,
                    table_high_byte_q, working_register_q};
                REG_PC:    o_avs_readdata <= {17'h00000, cycles_q, pc_q};
                default:   o_avs_readdata <= '0;
            endcase
        end
    end

endmodule // mcu_instruction_execute

`default_nettype wire

// ### bench/exec_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module exec_checker
    import exec_pkg::*;
(
    input wire logic              i_clk_sys,
    input wire logic              i_reset_n,
    input wire logic [3:0]        i_avs_address,
    input wire logic              i_avs_write,
    input wire logic [31:0]       i_avs_writedata,
    input wire logic              o_dmem_we,
    input wire logic [DATA_W-1:0] o_dmem_wdata,
    input wire logic [DATA_W-1:0] i_dmem_rdata,
    input wire logic [PC_W-1:0]   o_pmem_addr,
    input wire logic [15:0]       i_pmem_rdata,
    input wire logic              o_sys_clk_stop
);
    opcode_e    op_q;
    logic [2:0] bit_q;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            op_q  <= idle_op;
            bit_q <= '0;
        end else if (i_avs_write && i_avs_address == REG_INSTR) begin
            op_q  <= opcode_e'(i_avs_writedata[INSTR_OP_LSB +: OPC_W]);
            bit_q <= i_avs_writedata[INSTR_BIT_LSB +: BIT_SEL_W];
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    a_one_write_each: assert property (o_dmem_we |=> !o_dmem_we)
        else $error("write held");
    a_bit_only: assert property (o_dmem_we && op_q inside {zero_bit_op, set_bit_op} |->
        o_dmem_wdata == (op_q == set_bit_op ? (i_dmem_rdata | (8'h01 << bit_q))
                                            : (i_dmem_rdata & ~(8'h01 << bit_q))))
        else $error("bit op wrong");
    a_byte_fill: assert property (o_dmem_we && op_q inside {zero_op, set_byte_op} |->
        o_dmem_wdata == (op_q == zero_op ? ALL_ZEROS : ALL_ONES))
        else $error("byte fill wrong");
    a_invert_byte: assert property (o_dmem_we && op_q == invert_op |->
        o_dmem_wdata == ~i_dmem_rdata) else $error("invert wrong");
    a_swap_halves: assert property (o_dmem_we && op_q == nibble_exchange_op |->
        o_dmem_wdata == {i_dmem_rdata[3:0], i_dmem_rdata[7:4]})
        else $error("swap wrong");
    a_inc_result: assert property (o_dmem_we && op_q == inc_skip_zero_op |->
        o_dmem_wdata == i_dmem_rdata + 8'h01) else $error("inc wrong");
    a_reg_dest_quiet: assert property (op_q inside {copy_mem_to_wreg_op,
        copy_imm_to_wreg_op, nibble_exchange_to_wreg_op, inc_skip_zero_to_wreg_op,
        dec_skip_zero_to_wreg_op, skip_zero_copy_op} |-> !o_dmem_we)
        else $error("reg form wrote mem");
    a_table_low: assert property (o_dmem_we &&
        op_q inside {table_fetch_op, table_fetch_last_page_op} |->
        o_dmem_wdata == i_pmem_rdata[7:0]) else $error("table low byte wrong");
    a_last_page: assert property (o_dmem_we && op_q == table_fetch_last_page_op |->
        o_pmem_addr[12:8] == 5'h1f) else $error("not last page");
    a_halt_cause: assert property ($rose(o_sys_clk_stop) |-> op_q == halt_op)
        else $error("stop without halt");
endmodule // exec_checker
bind mcu_instruction_execute exec_checker u_checker (.i_clk_sys, .i_reset_n,
    .i_avs_address, .i_avs_write, .i_avs_writedata, .o_dmem_we, .o_dmem_wdata,
    .i_dmem_rdata, .o_pmem_addr, .i_pmem_rdata, .o_sys_clk_stop);
`default_nettype wire

// ### bench/exec_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
module exec_memory_model
    import exec_pkg::*;
(
    input wire logic              i_clk_sys,
    input wire logic [ADDR_W-1:0] i_dmem_addr,
    input wire logic              i_dmem_we,
    input wire logic [DATA_W-1:0] i_dmem_wdata,
    output logic [DATA_W-1:0]     o_dmem_rdata,
    input wire logic [PC_W-1:0]   i_pmem_addr,
    output logic [15:0]           o_pmem_rdata
);
    logic [DATA_W-1:0] mem [256];
    always @(posedge i_clk_sys) begin
        if (i_dmem_we) mem[i_dmem_addr] <= i_dmem_wdata;
    end
    assign o_dmem_rdata = mem[i_dmem_addr];
    assign o_pmem_rdata = {3'h0, i_pmem_addr} ^ 16'h00ff;
endmodule // exec_memory_model
`default_nettype wire

// ### bench/mcu_instruction_execute_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_execute_tb_top
    import exec_pkg::*;
    ;
    logic              i_clk_sys;
    logic              i_reset_n;
    logic              i_avs_read;
    logic              i_avs_write;
    logic [3:0]        i_avs_address;
    logic [3:0]        i_avs_byteenable;
    logic [31:0]       i_avs_writedata;
    logic [31:0]       o_avs_readdata;
    logic              o_avs_waitrequest;
    logic [ADDR_W-1:0] o_dmem_addr;
    logic              o_dmem_we;
    logic [DATA_W-1:0] o_dmem_wdata;
    logic [DATA_W-1:0] i_dmem_rdata;
    logic [PC_W-1:0]   o_pmem_addr;
    logic [15:0]       i_pmem_rdata;
    logic              o_sys_clk_stop;
    logic              o_watchdog_timeout;
    logic [31:0]       st;
    logic [31:0]       pcr;
    logic [PC_W-1:0]   pc0;
    int                errors;
    int                tests_run;
    opcode_e    sk_op [8] = '{skip_zero_op, skip_zero_op, skip_zero_copy_op,
        skip_bit_nonzero_op, skip_bit_zero_op, inc_skip_zero_op, dec_skip_zero_op,
        dec_skip_zero_to_wreg_op};
    logic [7:0] sk_in [8] = '{8'h00, 8'h07, 8'h00, 8'h80, 8'h80, 8'hff, 8'h03, 8'h01};
    logic [7:0] sk_out [8] = '{8'h00, 8'h07, 8'h00, 8'h80, 8'h80, 8'h00, 8'h02, 8'h01};
    logic [2:0] sk_bit [8] = '{3'h0, 3'h0, 3'h0, 3'h7, 3'h7, 3'h0, 3'h0, 3'h0};
    logic [1:0] sk_cyc [8] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2};
    opcode_e    wd_op [7] = '{watchdog_kick_first_half_op, watchdog_kick_first_half_op,
        idle_op, watchdog_kick_second_half_op, idle_op, watchdog_kick_first_half_op,
        watchdog_kick_second_half_op};
    logic [6:0] wd_pdf = 7'h3f;

    mcu_instruction_execute u_dut (.i_clk_sys, .i_reset_n, .i_avs_address, .i_avs_read,
        .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
        .o_avs_waitrequest, .o_dmem_addr, .o_dmem_we, .o_dmem_wdata, .i_dmem_rdata,
        .o_pmem_addr, .i_pmem_rdata, .o_sys_clk_stop, .o_watchdog_timeout);
    exec_memory_model u_mem (.i_clk_sys, .i_dmem_addr(o_dmem_addr), .i_dmem_we(o_dmem_we),
        .i_dmem_wdata(o_dmem_wdata), .o_dmem_rdata(i_dmem_rdata),
        .i_pmem_addr(o_pmem_addr), .o_pmem_rdata(i_pmem_rdata));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h0, e}, {7'h0, g});
    endtask
    task automatic cyc(input logic [1:0] e);
        chk8("cycles", {6'h0, e}, {6'h0, pcr[14:13]});
    endtask
    task automatic wait_ready();
        logic w;
        for (int n = 0; n < 50; n++) begin
            @(negedge i_clk_sys);
            w = o_avs_waitrequest;
            @(posedge i_clk_sys);
            if (w === 1'b0) return;
        end
        errors++;
        complete_run();
    endtask
    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= 1'b1;
        wait_ready();
        i_avs_write <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        i_avs_address <= a;
        i_avs_read <= 1'b1;
        wait_ready();
        d = o_avs_readdata;
        i_avs_read <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic run_op(input opcode_e op, input logic [7:0] a, input logic [7:0] imm,
                          input logic [2:0] b);
        int n;
        logic [31:0] w;
        w = '0;
        w[INSTR_OP_LSB +: OPC_W] = op;
        w[INSTR_BIT_LSB +: BIT_SEL_W] = b;
        w[INSTR_IMM_LSB +: DATA_W] = imm;
        w[INSTR_ADDR_LSB +: ADDR_W] = a;
        pc0 = pcr[PC_W-1:0];
        bus_write(REG_INSTR, w);
        bus_write(REG_CTRL, 32'h1);
        for (n = 0; n < 20; n++) begin
            bus_read(REG_STATE, st);
            if (st[ST_BUSY] === 1'b0) break;
        end
        if (n == 20) begin
            errors++;
            complete_run();
        end
        bus_read(REG_PC, pcr);
    endtask

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        i_reset_n = 1'b0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_address = 4'h0;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'hf;
        pcr = 32'h0;
        errors = 0;
        tests_run = 0;
        repeat (4) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        @(posedge i_clk_sys);
        u_mem.mem[8'h21] <= 8'ha5;
        u_mem.mem[8'h23] <= 8'h5a;
        u_mem.mem[8'h24] <= 8'h0f;
        u_mem.mem[8'h25] <= 8'h12;
        u_mem.mem[8'h30] <= 8'h80;
        u_mem.mem[8'h31] <= 8'h01;
        u_mem.mem[8'h32] <= 8'hf3;
        u_mem.mem[8'h33] <= 8'h10;
        for (int i = 0; i < 8; i++) u_mem.mem[8'h40 + i] <= sk_in[i];
        run_op(copy_imm_to_wreg_op, 8'h00, 8'h3c, 3'h0);
        chk8("wreg", 8'h3c, st[7:0]);
        cyc(2'h1);
        run_op(copy_wreg_to_mem_op, 8'h20, 8'h00, 3'h0);
        chk8("mem20", 8'h3c, u_mem.mem[8'h20]);
        run_op(copy_mem_to_wreg_op, 8'h21, 8'h00, 3'h0);
        chk8("wreg", 8'ha5, st[7:0]);
        run_op(zero_bit_op, 8'h21, 8'h00, 3'h0);
        chk8("mem21", 8'ha4, u_mem.mem[8'h21]);
        run_op(set_bit_op, 8'h21, 8'h00, 3'h6);
        chk8("mem21", 8'he4, u_mem.mem[8'h21]);
        run_op(zero_op, 8'h22, 8'h00, 3'h0);
        chk8("mem22", 8'h00, u_mem.mem[8'h22]);
        run_op(set_byte_op, 8'h22, 8'h00, 3'h0);
        chk8("mem22", 8'hff, u_mem.mem[8'h22]);
        chk8("mem23", 8'h5a, u_mem.mem[8'h23]);
        run_op(invert_op, 8'h24, 8'h00, 3'h0);
        chk8("mem24", 8'hf0, u_mem.mem[8'h24]);
        run_op(nibble_exchange_to_wreg_op, 8'h25, 8'h00, 3'h0);
        chk8("wreg", 8'h21, st[7:0]);
        chk8("mem25", 8'h12, u_mem.mem[8'h25]);
        run_op(nibble_exchange_op, 8'h25, 8'h00, 3'h0);
        chk8("mem25", 8'h21, u_mem.mem[8'h25]);
        run_op(copy_wreg_to_mem_op, PCL_ADDR, 8'h00, 3'h0);
        cyc(2'h2);
        $display("test moves done");
        for (int i = 0; i < 8; i++) begin
            run_op(sk_op[i], 8'h40 + 8'(i), 8'h00, sk_bit[i]);
            cyc(sk_cyc[i]);
            chk8("pc step", {6'h0, sk_cyc[i]}, 8'(pcr[PC_W-1:0] - pc0));
            chk8("skip mem", sk_out[i], u_mem.mem[8'h40 + i]);
        end
        chk8("wreg", 8'h00, st[7:0]);
        $display("test skips done");
        run_op(copy_imm_to_wreg_op, 8'h00, 8'h7f, 3'h0);
        run_op(add_imm_op, 8'h00, 8'h01, 3'h0);
        chk8("wreg", 8'h80, st[7:0]);
        chk8("flags", 8'h0a, {4'h0, st[ST_OV:ST_C]});
        run_op(add_with_carry_to_mem_op, 8'h30, 8'h00, 3'h0);
        chk8("mem30", 8'h00, u_mem.mem[8'h30]);
        chk8("flags", 8'h0d, {4'h0, st[ST_OV:ST_C]});
        run_op(add_with_carry_op, 8'h31, 8'h00, 3'h0);
        chk8("wreg", 8'h82, st[7:0]);
        chk8("flags", 8'h00, {4'h0, st[ST_OV:ST_C]});
        run_op(bitwise_conj_to_mem_op, 8'h32, 8'h00, 3'h0);
        chk8("mem32", 8'h82, u_mem.mem[8'h32]);
        run_op(and_imm_op, 8'h00, 8'h7d, 3'h0);
        chk1("zero", 1'b1, st[ST_Z]);
        run_op(sum_to_mem_op, 8'h33, 8'h00, 3'h0);
        chk8("mem33", 8'h10, u_mem.mem[8'h33]);
        $display("test arith done");
        run_op(copy_imm_to_wreg_op, 8'h00, 8'h34, 3'h0);
        run_op(table_fetch_last_page_op, 8'h38, 8'h00, 3'h0);
        cyc(2'h2);
        chk8("table high", 8'h1f, st[15:8]);
        chk8("mem38", 8'hcb, u_mem.mem[8'h38]);
        run_op(call_op, 8'h50, 8'h00, 3'h0);
        cyc(2'h2);
        run_op(subroutine_exit_imm_op, 8'h00, 8'h99, 3'h0);
        cyc(2'h2);
        chk8("wreg", 8'h99, st[7:0]);
        run_op(call_op, 8'h60, 8'h00, 3'h0);
        run_op(interrupt_exit_op, 8'h00, 8'h00, 3'h0);
        chk1("irq enable", 1'b1, st[ST_IRQ_EN]);
        $display("test flow done");
        run_op(halt_op, 8'h00, 8'h00, 3'h0);
        cyc(2'h1);
        chk1("powerdown", 1'b1, st[ST_PDF]);
        chk1("timeout", 1'b0, st[ST_TO]);
        chk1("clock stop", 1'b1, o_sys_clk_stop);
        bus_write(REG_CTRL, 32'h2);
        for (int i = 0; i < 7; i++) begin
            run_op(wd_op[i], 8'h00, 8'h00, 3'h0);
            chk1("powerdown", wd_pdf[i], st[ST_PDF]);
        end
        run_op(halt_op, 8'h00, 8'h00, 3'h0);
        bus_write(REG_CTRL, 32'h2);
        run_op(watchdog_kick_op, 8'h00, 8'h00, 3'h0);
        chk1("powerdown", 1'b0, st[ST_PDF]);
        cyc(2'h1);
        $display("test watchdog done");
        complete_run();
    end
endmodule // mcu_instruction_execute_tb_top
`default_nettype wire
